// ==== rtl/pwr_seq_pkg.sv ====
// Constants, types and helpers shared by the power-on and standby controller
package pwr_seq_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Times in microseconds, as specified
  localparam int unsigned T_OFF_MAX_US = 5_000;
  localparam int unsigned T_ON_MIN_US = 5_000;
  localparam int unsigned T_ON_MAX_US = 400_000;
  localparam int unsigned T_PG_DROP_MAX_US = 5_000;
  localparam int unsigned T_PG_MIN_US = 100_000;
  localparam int unsigned T_PG_MAX_US = 500_000;
  localparam int unsigned T_STBY1_US = 800_000;
  localparam int unsigned T_STBY2_US = 600_000;
  localparam int unsigned T_STBY3_US = 400_000;
  localparam int unsigned T_BLINK_US = 500_000;

  // Least times are whole multiples of the clock, so the minimum figure is used exactly
  localparam int unsigned ON_CYC = (T_ON_MIN_US * CYC_PER_US);
  localparam int unsigned PG_CYC = (T_PG_MIN_US * CYC_PER_US);
  localparam int unsigned STBY1_CYC = (T_STBY1_US * CYC_PER_US);
  localparam int unsigned STBY2_CYC = (T_STBY2_US * CYC_PER_US);
  localparam int unsigned STBY3_CYC = (T_STBY3_US * CYC_PER_US);
  localparam int unsigned BLINK_CYC = (T_BLINK_US * CYC_PER_US);
  localparam int unsigned CNT_W = 24;

  // Role register, reached by its command code
  localparam logic [7:0] ROLE_CMD = 8'hd0;
  localparam logic [7:0] ROLE_RESET = 8'h00;
  localparam logic [7:0] ROLE_STANDARD = 8'h00;
  localparam logic [7:0] ROLE_ACTIVE = 8'h01;
  localparam logic [7:0] ROLE_STBY1 = 8'h02;
  localparam logic [7:0] ROLE_STBY2 = 8'h03;
  localparam logic [7:0] ROLE_STBY3 = 8'h04;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [6:0] SMB_ADDR_DEF = 7'h58;

  typedef enum logic [2:0] {P_OFF, P_RAMP, P_ON, P_DOZE, P_STBY} power_e;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_RACK, S_TX, S_TACK} smb_e;

  typedef struct packed {
    logic oc_warn;
    logic oc_fault;
    logic overvoltage_trip;
    logic undervoltage_trip;
    logic overtemp;
    logic fan_fault;
    logic input_loss;
  } mon_s;

  // Packet error check byte, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// ==== rtl/power_on_and_standby_control.sv ====
// Power-on sequencing, power-good and cold-standby role control with byte command port
`timescale 1ns/1ns
module power_on_and_standby_control #(
  parameter logic [6:0] SMB_ADDR = pwr_seq_pkg::SMB_ADDR_DEF,
  parameter int unsigned ON_CYC = pwr_seq_pkg::ON_CYC,
  parameter int unsigned PG_CYC = pwr_seq_pkg::PG_CYC,
  parameter int unsigned STBY1_CYC = pwr_seq_pkg::STBY1_CYC,
  parameter int unsigned STBY2_CYC = pwr_seq_pkg::STBY2_CYC,
  parameter int unsigned STBY3_CYC = pwr_seq_pkg::STBY3_CYC,
  parameter int unsigned BLINK_CYC = pwr_seq_pkg::BLINK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic remote_power_on_pin_n,
  input wire logic wake_bus,
  input wire logic redundancy_mode_n,
  input wire logic redundancy_fault_in_n,
  output logic redundancy_fault_n_o,
  output logic redundancy_fault_n_oe,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire pwr_seq_pkg::mon_s mon,
  input wire logic warning,
  input wire logic rail_in_regulation,
  input wire logic load_below_preset,
  input wire logic [2:0] load_share_over,
  output logic main_rail_en,
  output logic standby_rail_en,
  output logic power_good,
  output logic fan_run,
  output logic led_green,
  output logic led_amber,
  output logic fault_report,
  output logic [7:0] role
);

  localparam int W = pwr_seq_pkg::CNT_W;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic pson;
  logic wake_high;
  logic red_mode_off;
  logic peer_fault;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic smb_start;
  logic smb_stop;

  pwr_seq_pkg::power_e pwr_q;
  pwr_seq_pkg::smb_e smb_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] pg_cnt_q;
  logic [W-1:0] blink_cnt_q;
  logic blink_q;
  logic fault_latch_q;
  logic [7:0] role_q;
  logic shutdown;
  logic fault_any;
  logic red_trigger;
  logic stby_role;
  logic stby_ok;
  logic stby_wake;
  logic [W-1:0] doze_cyc;
  logic [1:0] position;

  logic [7:0] sh_q;
  logic [7:0] tx_sh_q;
  logic [7:0] crc_q;
  logic [7:0] data_q;
  logic [3:0] bit_cnt_q;
  logic [2:0] byte_n_q;
  logic cmd_ok_q;
  logic rd_q;
  logic acked_q;
  logic pec_sent_q;
  logic wr_stb_q;
  logic sda_oe_q;
  logic rx_ack;

  // Reset released through two flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pin synchronisers; the second stage feeds logic, plus a third flop on SCL and SDA for edge detection
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {sda_i, scl_i, redundancy_fault_in_n, redundancy_mode_n, wake_bus};
      sync2_q <= sync1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic [1:0] sync_pson_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sync_pson_q <= 2'h3;
    else
      sync_pson_q <= {sync_pson_q[0], remote_power_on_pin_n};
  end

  // Open pin reads high, so a floating power-on pin means off
  assign pson = ~sync_pson_q[1];

  assign wake_high = sync2_q[0];
  assign red_mode_off = sync2_q[1];
  assign peer_fault = ~sync2_q[2];
  assign scl_s = sync2_q[3];
  assign sda_s = sync2_q[4];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign smb_start = scl_s & scl_p_q & ~sda_s & sda_p_q;
  assign smb_stop = scl_s & scl_p_q & sda_s & ~sda_p_q;

  assign shutdown = mon.oc_fault | mon.overvoltage_trip | mon.overtemp | mon.fan_fault
    | mon.input_loss;
  assign fault_any = shutdown | mon.undervoltage_trip;

  assign red_trigger = fault_any | mon.oc_warn | ~pson
    | (role_q == pwr_seq_pkg::ROLE_STANDARD);

  assign stby_role = (role_q == pwr_seq_pkg::ROLE_STBY1) | (role_q == pwr_seq_pkg::ROLE_STBY2)
    | (role_q == pwr_seq_pkg::ROLE_STBY3);
  assign stby_ok = pson & red_mode_off & stby_role & wake_high & load_below_preset
    & ~fault_any & ~peer_fault;
  assign position = 2'(role_q - pwr_seq_pkg::ROLE_STBY1);

  always_comb
  begin
    unique case (role_q)
      pwr_seq_pkg::ROLE_STBY1: doze_cyc = W'(STBY1_CYC - 1);
      pwr_seq_pkg::ROLE_STBY2: doze_cyc = W'(STBY2_CYC - 1);
      default: doze_cyc = W'(STBY3_CYC - 1);
    endcase
  end

  assign stby_wake = ~wake_high | peer_fault | fault_any | ~stby_role | ~red_mode_off
    | (position <= 2'h2 && load_share_over[position]);

  // Latched trips clear only by taking the power-on pin away
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fault_latch_q <= 1'b0;
    else if (mon.oc_fault | mon.overvoltage_trip)
      fault_latch_q <= 1'b1;
    else if (!pson)
      fault_latch_q <= 1'b0;
  end

  // Main power sequence
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_q <= pwr_seq_pkg::P_OFF;
      cnt_q <= '0;
    end
    // pin released: rail off next cycle
    else if (!pson || shutdown)
    begin
      pwr_q <= pwr_seq_pkg::P_OFF;
      cnt_q <= '0;
    end
    else
    begin
      unique case (pwr_q)
        pwr_seq_pkg::P_OFF:
        begin
          cnt_q <= '0;
          if (!fault_latch_q)
            pwr_q <= pwr_seq_pkg::P_RAMP;
        end
        pwr_seq_pkg::P_RAMP:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == W'(ON_CYC - 1))
            pwr_q <= pwr_seq_pkg::P_ON;
        end
        // role 01h leaves this state only on pin release or a shutdown trip
        pwr_seq_pkg::P_ON:
        begin
          cnt_q <= '0;
          if (stby_ok)
            pwr_q <= pwr_seq_pkg::P_DOZE;
        end
        pwr_seq_pkg::P_DOZE:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (!stby_ok)
            pwr_q <= pwr_seq_pkg::P_ON;
          else if (cnt_q == doze_cyc)
            pwr_q <= pwr_seq_pkg::P_STBY;
        end
        // power back on at once when woken
        pwr_seq_pkg::P_STBY:
        begin
          cnt_q <= '0;
          if (stby_wake)
            pwr_q <= pwr_seq_pkg::P_ON;
        end
      endcase
    end
  end

  // power-good after 100 ms in regulation
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pg_cnt_q <= '0;
    else if (pwr_q == pwr_seq_pkg::P_OFF || pwr_q == pwr_seq_pkg::P_RAMP)
      pg_cnt_q <= '0;
    else if (!rail_in_regulation && pwr_q != pwr_seq_pkg::P_STBY)
      pg_cnt_q <= '0;
    else if (pg_cnt_q != W'(PG_CYC))
      pg_cnt_q <= pg_cnt_q + 1'b1;
  end

  // Blink timebase for the indicator
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end
    else if (blink_cnt_q == W'(BLINK_CYC - 1))
    begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 1'b1;
  end

  // Outputs, all registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_rail_en <= 1'b0;
      power_good <= 1'b0;
      fan_run <= 1'b0;
      led_green <= 1'b0;
      led_amber <= 1'b0;
      fault_report <= 1'b0;
      redundancy_fault_n_oe <= 1'b0;
    end
    else
    begin
      // rail on in the powered states
      main_rail_en <= pson & ~shutdown
        & (pwr_q == pwr_seq_pkg::P_ON || pwr_q == pwr_seq_pkg::P_DOZE);
      // drops with the pin, held in standby
      power_good <= pson & ~shutdown & (pg_cnt_q == W'(PG_CYC));
      fan_run <= pwr_q != pwr_seq_pkg::P_OFF;
      if (pwr_q == pwr_seq_pkg::P_STBY)
      begin
        led_green <= blink_q & ~warning;
        led_amber <= blink_q & warning;
      end
      else
      begin
        led_green <= main_rail_en & ~fault_any & ~warning;
        led_amber <= fault_any | warning;
      end
      fault_report <= fault_any & (pwr_q != pwr_seq_pkg::P_STBY);
      // a module in standby never pulls the line
      redundancy_fault_n_oe <= red_trigger & (pwr_q != pwr_seq_pkg::P_STBY);
    end
  end

  assign redundancy_fault_n_o = 1'b0;
  // Standby rail is never switched by this logic
  assign standby_rail_en = 1'b1;

  // fault wins over a concurrent write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      role_q <= pwr_seq_pkg::ROLE_STANDARD;
    else if (fault_any)
      role_q <= pwr_seq_pkg::ROLE_RESET;
    else if (wr_stb_q)
      role_q <= data_q;
  end
  assign role = role_q;

  // accept address, D0h, data and a valid check byte
  always_comb
  begin
    unique case (byte_n_q)
      3'h0: rx_ack = (sh_q[7:1] == SMB_ADDR) & (~sh_q[0] | cmd_ok_q);
      3'h1: rx_ack = (sh_q == pwr_seq_pkg::ROLE_CMD);
      3'h2: rx_ack = 1'b1;
      3'h3: rx_ack = (sh_q == crc_q) & ~rd_q;
      default: rx_ack = 1'b0;
    endcase
  end

  // Byte-level command port; no clock stretching, so SCL is never driven
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smb_q <= pwr_seq_pkg::S_IDLE;
      sh_q <= '0;
      tx_sh_q <= '0;
      crc_q <= pwr_seq_pkg::CRC_INIT;
      data_q <= '0;
      bit_cnt_q <= '0;
      byte_n_q <= '0;
      cmd_ok_q <= 1'b0;
      rd_q <= 1'b0;
      acked_q <= 1'b0;
      pec_sent_q <= 1'b0;
      wr_stb_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (smb_start)
      begin
        // Repeated start keeps the command and the running check
        if (smb_q == pwr_seq_pkg::S_IDLE)
        begin
          crc_q <= pwr_seq_pkg::CRC_INIT;
          cmd_ok_q <= 1'b0;
        end
        smb_q <= pwr_seq_pkg::S_RX;
        bit_cnt_q <= '0;
        byte_n_q <= '0;
        rd_q <= 1'b0;
        pec_sent_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (smb_stop)
      begin
        smb_q <= pwr_seq_pkg::S_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        unique case (smb_q)
          pwr_seq_pkg::S_IDLE:
            sda_oe_q <= 1'b0;
          pwr_seq_pkg::S_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              if (rx_ack)
              begin
                sda_oe_q <= 1'b1;
                smb_q <= pwr_seq_pkg::S_RACK;
                crc_q <= pwr_seq_pkg::crc8(crc_q, sh_q);
                byte_n_q <= byte_n_q + 1'b1;
                if (byte_n_q == 3'h0)
                  rd_q <= sh_q[0];
                if (byte_n_q == 3'h1)
                  cmd_ok_q <= 1'b1;
                if (byte_n_q == 3'h2)
                  data_q <= sh_q;
                if (byte_n_q == 3'h3)
                  wr_stb_q <= 1'b1;
              end
              else
                smb_q <= pwr_seq_pkg::S_IDLE;
            end
          end
          pwr_seq_pkg::S_RACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_q <= '0;
              if (rd_q)
              begin
                smb_q <= pwr_seq_pkg::S_TX;
                tx_sh_q <= role_q;
                crc_q <= pwr_seq_pkg::crc8(crc_q, role_q);
                sda_oe_q <= ~role_q[7];
              end
              else
              begin
                smb_q <= pwr_seq_pkg::S_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          pwr_seq_pkg::S_TX:
          begin
            if (scl_rise)
              bit_cnt_q <= bit_cnt_q + 1'b1;
            else if (scl_fall)
            begin
              if (bit_cnt_q == 4'h8)
              begin
                sda_oe_q <= 1'b0;
                smb_q <= pwr_seq_pkg::S_TACK;
              end
              else
              begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                sda_oe_q <= ~tx_sh_q[6];
              end
            end
          end
          pwr_seq_pkg::S_TACK:
          begin
            if (scl_rise)
              acked_q <= ~sda_s;
            else if (scl_fall)
            begin
              bit_cnt_q <= '0;
              if (acked_q && !pec_sent_q)
              begin
                tx_sh_q <= crc_q;
                sda_oe_q <= ~crc_q[7];
                pec_sent_q <= 1'b1;
                smb_q <= pwr_seq_pkg::S_TX;
              end
              else
                smb_q <= pwr_seq_pkg::S_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;

endmodule // power_on_and_standby_control

// ==== dv/pwr_ctrl_asserts.sv ====
// Port-level checker for the power-on and standby controller
`timescale 1ns/1ns
module pwr_ctrl_asserts #(
  parameter int unsigned ON_CYC = 20,
  parameter int unsigned PG_CYC = 40
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic remote_power_on_pin_n,
  input wire logic wake_bus,
  input wire logic redundancy_fault_in_n,
  input wire logic rail_in_regulation,
  input wire pwr_seq_pkg::mon_s mon,
  input wire logic redundancy_fault_n_o,
  input wire logic redundancy_fault_n_oe,
  input wire logic main_rail_en,
  input wire logic power_good,
  input wire logic fan_run,
  input wire logic [7:0] role
);
  localparam int ON_MAX = ON_CYC + 10;
  localparam int PG_MAX = PG_CYC + 6;
  int low_cnt;
  int reg_cnt;
  logic fault_seen;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Saturating counts; caps sit far above the checked figures at this module's default parameters
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) low_cnt <= 0;
    else if (remote_power_on_pin_n) low_cnt <= 0;
    else if (low_cnt < 4095) low_cnt <= low_cnt + 1;

  always_ff @(posedge clock or negedge nrst)
    if (!nrst) reg_cnt <= 0;
    else if (!(rail_in_regulation && main_rail_en)) reg_cnt <= 0;
    else if (reg_cnt < 4095) reg_cnt <= reg_cnt + 1;

  // Over-current and overvoltage trips latch until the pin is released, so timing limits are waived after any trip
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) fault_seen <= 1'b0;
    else if (remote_power_on_pin_n) fault_seen <= 1'b0;
    else if (|mon[5:0]) fault_seen <= 1'b1;

  sequence s_pin_off;
    $rose(remote_power_on_pin_n);
  endsequence
  sequence s_standby;
    power_good && !main_rail_en && !remote_power_on_pin_n;
  endsequence

  property p_rail_off;
    s_pin_off |-> ##[1:6] !main_rail_en;
  endproperty
  property p_pg_drop;
    s_pin_off |-> ##[1:6] !power_good;
  endproperty
  property p_on_min;
    $rose(main_rail_en) |-> low_cnt >= ON_CYC;
  endproperty
  property p_on_max;
    low_cnt == ON_MAX && !fault_seen && mon == '0 |-> main_rail_en;
  endproperty
  property p_pg_min;
    $rose(power_good) |-> reg_cnt >= PG_CYC - 2;
  endproperty
  property p_pg_max;
    reg_cnt == PG_MAX && !fault_seen && mon == '0 |-> power_good;
  endproperty
  property p_pin_high;
    remote_power_on_pin_n [*8] |-> !main_rail_en && !power_good;
  endproperty
  property p_keep_on;
    main_rail_en && low_cnt > 4 && mon == '0 && $past(mon) == '0
      && !(role inside {8'h02, 8'h03, 8'h04}) |=> main_rail_en;
  endproperty
  property p_stby_fan;
    s_standby |-> fan_run;
  endproperty
  property p_wake;
    s_standby ##0 !wake_bus |-> ##[1:6] main_rail_en;
  endproperty
  property p_peer;
    s_standby ##0 !redundancy_fault_in_n |-> ##[1:6] main_rail_en;
  endproperty
  property p_fault_role;
    |mon[5:0] |-> ##[1:4] role == 8'h00;
  endproperty
  property p_fault_line;
    |mon[5:0] || role == 8'h00 |-> ##[1:5] redundancy_fault_n_oe;
  endproperty
  property p_open_drain;
    redundancy_fault_n_oe |-> !redundancy_fault_n_o;
  endproperty

  a_rail_off: assert property (p_rail_off)
    else $error("main rail still on after pin release");
  a_pg_drop: assert property (p_pg_drop)
    else $error("power good still high after pin release");
  a_on_min: assert property (p_on_min)
    else $error("main rail up too early");
  a_on_max: assert property (p_on_max)
    else $error("main rail not up in time");
  a_pg_min: assert property (p_pg_min)
    else $error("power good too early");
  a_pg_max: assert property (p_pg_max)
    else $error("power good not up in time");
  a_pin_high: assert property (p_pin_high)
    else $error("outputs on while pin high");
  a_keep_on: assert property (p_keep_on)
    else $error("rail dropped without standby role");
  a_stby_fan: assert property (p_stby_fan)
    else $error("fans stopped in standby");
  a_wake: assert property (p_wake)
    else $error("standby ignored wake bus");
  a_peer: assert property (p_peer)
    else $error("standby ignored peer fault");
  a_fault_role: assert property (p_fault_role)
    else $error("role not cleared by fault");
  a_fault_line: assert property (p_fault_line)
    else $error("fault line not pulled");
  a_open_drain: assert property (p_open_drain)
    else $error("fault line drives high");
endmodule // pwr_ctrl_asserts

bind power_on_and_standby_control pwr_ctrl_asserts #(
  .ON_CYC(ON_CYC),
  .PG_CYC(PG_CYC)
) u_pwr_ctrl_asserts (.clock, .nrst, .remote_power_on_pin_n, .wake_bus,
  .redundancy_fault_in_n, .rail_in_regulation, .mon, .redundancy_fault_n_o,
  .redundancy_fault_n_oe, .main_rail_en, .power_good, .fan_run, .role);

// ==== dv/smb_host_model.sv ====
// Host side model: slow SMBus master writing the role register
`timescale 1ns/1ns
module smb_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Eight clocks per phase keeps well above the controller's SCL minimum
  task automatic phase(input logic s, input logic p);
    @(posedge clock);
    scl <= s;
    sda_pull <= p;
    repeat (7) @(posedge clock);
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      phase(1'b0, ~b[i]);
      phase(1'b1, ~b[i]);
      phase(1'b0, ~b[i]);
    end
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    ack = !sda;
    phase(1'b0, 1'b0);
  endtask

  task automatic write_role(input logic [7:0] aw, input logic [7:0] d, input logic bad,
                            output int acks);
    logic [7:0] pec;
    logic a;
    pec = crc_step(crc_step(crc_step(8'h00, aw), 8'hd0), d) ^ {7'h00, bad};
    acks = 0;
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
    send_byte(aw, a);
    acks += a;
    send_byte(8'hd0, a);
    acks += a;
    send_byte(d, a);
    acks += a;
    send_byte(pec, a);
    acks += a;
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
  endtask

  // Reads one byte msb first, then acks it (ack high) or refuses it
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
      b[i] = sda;
    end
    phase(1'b0, ack);
    phase(1'b1, ack);
    phase(1'b0, ack);
  endtask

  // read byte with check, repeated start before the read address
  task automatic read_role(input logic [7:0] aw, output logic [7:0] d, output logic pok);
    logic a;
    logic [7:0] pec;
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
    send_byte(aw, a);
    send_byte(8'hd0, a);
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
    send_byte(aw | 8'h01, a);
    recv_byte(1'b1, d);
    recv_byte(1'b0, pec);
    pok = (pec == crc_step(crc_step(crc_step(crc_step(8'h00, aw), 8'hd0), aw | 8'h01), d));
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
  endtask
endmodule // smb_host_model

// ==== dv/testbench.sv ====
// Self-checking bench for the power-on and standby controller
`timescale 1ns/1ns
module testbench;
  localparam int ON_C = 20;
  localparam int PG_C = 40;
  localparam int STBY_C[3] = '{80, 60, 40};
  localparam logic [7:0] AW = {pwr_seq_pkg::SMB_ADDR_DEF, 1'b0};
  logic clock, nrst, pin_n, wake, mode_n, peer_pull, reg_ok, load_low;
  logic [2:0] share_over;
  pwr_seq_pkg::mon_s mon;
  logic fault_o, fault_oe, sda_o, sda_oe, scl, host_pull, main_en, sb_en, pg;
  logic fan, led_g, led_a, f_rep, warn;
  logic [7:0] role;
  wire sda = !(sda_oe || host_pull);
  wire red_n = !(fault_oe || peer_pull);
  int fails = 0;
  int checked = 0;
  int exp_role = 0;
  int roles[$] = '{2, 3, 4};

  always #25 clock = ~clock;

  power_on_and_standby_control #(.ON_CYC(ON_C), .PG_CYC(PG_C), .STBY1_CYC(STBY_C[0]),
    .STBY2_CYC(STBY_C[1]), .STBY3_CYC(STBY_C[2]), .BLINK_CYC(8))
  u_power_on_and_standby_control (.clock(clock), .nrst(nrst),
    .remote_power_on_pin_n(pin_n), .wake_bus(wake), .redundancy_mode_n(mode_n),
    .redundancy_fault_in_n(red_n), .redundancy_fault_n_o(fault_o),
    .redundancy_fault_n_oe(fault_oe), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .mon(mon), .warning(warn), .rail_in_regulation(reg_ok),
    .load_below_preset(load_low), .load_share_over(share_over), .main_rail_en(main_en),
    .standby_rail_en(sb_en), .power_good(pg), .fan_run(fan), .led_green(led_g),
    .led_amber(led_a), .fault_report(f_rep), .role(role));

  smb_host_model u_smb_host_model (.clock(clock), .sda(sda), .scl(scl),
    .sda_pull(host_pull));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int n, input int lo, input int hi, input string what);
    checked++;
    if (n < lo || n > hi)
    begin
      fails++;
      $display("[FAIL] %0t %s took %0d", $time, what, n);
    end
  endtask

  task automatic wait_for(input bit sel_pg, input logic v, output int n);
    n = 0;
    while ((sel_pg ? pg : main_en) !== v && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    // Return on a rising edge so the caller drives inputs there
    @(posedge clock);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic set_role(input int r, input bit bad);
    int acks;
    u_smb_host_model.write_role(AW, r[7:0], bad, acks);
    if (!bad)
      exp_role = r;
    chk_n(acks, bad ? 3 : 4, bad ? 3 : 4, "acks");
    tick(4);
    chk(role, exp_role[7:0], "role");
  endtask

  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    tick(40000);
    fails++;
    end_of_test;
  end

  initial
  begin
    int n;
    int n2;
    int src;
    int seed_v;
    logic [7:0] rd_d;
    logic rd_ok;
    clock = 1'b0;
    nrst = 1'b0;
    pin_n = 1'b1;
    wake = 1'b1;
    mode_n = 1'b1;
    peer_pull = 1'b0;
    reg_ok = 1'b0;
    load_low = 1'b0;
    warn = 1'b0;
    share_over = 3'h0;
    mon = '0;
    seed_v = $urandom(32'hb8e1);
    tick(20);
    nrst <= 1'b1;
    tick(6);
    chk(role, 8'h00, "role reset");
    chk({5'h00, sda_o, sb_en, main_en}, 8'h02, "rails at reset");
    chk({7'h00, fault_oe}, 8'h01, "fault line at reset");
    $display("test reset done");
    pin_n <= 1'b0;
    wait_for(0, 1'b1, n);
    chk_n(n, ON_C, ON_C * 80, "rail up");
    reg_ok <= 1'b1;
    wait_for(1, 1'b1, n);
    chk_n(n, PG_C, PG_C * 5, "power good");
    $display("test power up done");
    for (int i = 0; i < 3; i++)
    begin
      set_role(roles[i], 1'b0);
      mode_n <= 1'b0;
      load_low <= 1'b1;
      tick(STBY_C[i] + 10);
      chk({7'h00, main_en}, 8'h01, "no standby in mode");
      mode_n <= 1'b1;
      wait_for(0, 1'b0, n);
      chk_n(n, STBY_C[i], STBY_C[i] + 8, "standby delay");
      chk({6'h00, pg, fan}, 8'h03, "standby keeps good");
      // blink in the colour of the warning state
      warn <= i[0];
      tick(2);
      n2 = 0;
      repeat (20)
      begin
        @(negedge clock);
        n2 += int'(i[0] ? led_a : led_g);
        chk({7'h00, i[0] ? led_g : led_a}, 8'h00, "steady led");
      end
      chk_n(n2, 4, 16, "standby blink");
      tick(1);
      warn <= 1'b0;
      src = (i + $urandom_range(3)) % 4;
      if (src == 0)
        wake <= 1'b0;
      else if (src == 1)
        peer_pull <= 1'b1;
      else if (src == 2)
        share_over[i] <= 1'b1;
      else
        mon.undervoltage_trip <= 1'b1;
      wait_for(0, 1'b1, n);
      chk_n(n, 1, 6, "wake");
      if (src == 3)
        chk({7'h00, f_rep}, 8'h01, "fault leaves standby");
      load_low <= 1'b0;
      wake <= 1'b1;
      peer_pull <= 1'b0;
      share_over <= 3'h0;
      mon <= '0;
      tick(6);
      $display("test standby role %0d done", roles[i]);
    end
    set_role(1, 1'b0);
    load_low <= 1'b1;
    tick(STBY_C[0] + 10);
    chk({7'h00, main_en}, 8'h01, "always on role");
    load_low <= 1'b0;
    set_role(0, 1'b0);
    chk({7'h00, fault_oe}, 8'h01, "fault line on role 00");
    set_role(2, 1'b1);
    $display("test role write done");
    set_role(3, 1'b0);
    u_smb_host_model.read_role(AW, rd_d, rd_ok);
    chk(rd_d, exp_role[7:0], "read role");
    chk({7'h00, rd_ok}, 8'h01, "read check byte");
    mon.overtemp <= 1'b1;
    tick(6);
    exp_role = 0;
    chk(role, 8'h00, "role after fault");
    chk({7'h00, f_rep}, 8'h01, "fault reported");
    chk({6'h00, fault_oe, main_en}, 8'h02, "fault shutdown");
    mon <= '0;
    tick(ON_C * 2 + PG_C * 2);
    pin_n <= 1'b1;
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b0, n2);
    chk_n(n + n2, 1, ON_C, "power off");
    chk({7'h00, sb_en}, 8'h01, "standby rail kept");
    $display("test fault and off done");
    end_of_test;
  end
endmodule // testbench
